/* File: rtl/anreg_pkg.sv */
// Constants shared by the auto-negotiation register set
package anreg_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  // Register offsets on the management port
  localparam logic [4:0] ADDR_ADV = 5'h04;
  localparam logic [4:0] ADDR_LP = 5'h05;
  localparam logic [4:0] ADDR_EXP = 5'h06;
  localparam logic [4:0] ADDR_CFG = 5'h10;
  // Field positions shared by advertisement and partner words
  localparam int unsigned POS_NEXT_PAGE = 15;
  localparam int unsigned POS_ACK = 14;
  localparam int unsigned POS_REMOTE_FAULT = 13;
  localparam int unsigned POS_FC = 10;
  localparam int unsigned POS_T4 = 9;
  localparam int unsigned POS_SEL_MSB = 4;
  // Expansion field positions
  localparam int unsigned POS_PAR_FAULT = 4;
  localparam int unsigned POS_LP_NEXT = 3;
  localparam int unsigned POS_LOCAL_NEXT = 2;
  localparam int unsigned POS_PAGE = 1;
  localparam int unsigned POS_LP_AN = 0;
  // Configuration field positions
  localparam int unsigned POS_BLK_BYP = 15;
  localparam int unsigned POS_SCR_BYP = 14;
  // Storable bits and reset values
  localparam logic [15:0] ADV_WR_MASK = 16'h25FF;
  localparam logic [15:0] ADV_RESET = 16'h01E1;
  localparam logic [15:0] LP_CAPTURE_MASK = 16'hE7FF;
  localparam logic [15:0] LP_RESET = 16'h0000;
  localparam logic [15:0] CFG_WR_MASK = 16'hC000;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] READ_NONE = 16'h0000;
  localparam int unsigned RESET_SYNC_STAGES = 2;
endpackage

/* File: rtl/anreg_exp_if.sv */
// Latched expansion flags: set and clear requests, and the flag levels
`timescale 1ns/10ps
`default_nettype none
interface anreg_exp_if;
  logic fault_set;
  logic page_set;
  logic rd_clear;
  logic fault_flag;
  logic page_flag;
  modport ctl (output fault_set, output page_set, output rd_clear,
               input fault_flag, input page_flag);
  modport keeper (input fault_set, input page_set, input rd_clear,
                  output fault_flag, output page_flag);
endinterface
`default_nettype wire

/* File: rtl/anreg_latch_flags.sv */
// Latch-high flags of the expansion register, cleared by a register read
`timescale 1ns/10ps
`default_nettype none
module anreg_latch_flags (
  input wire logic clk_i,     // System clock
  input wire logic rst_n_i,   // Synchronised reset, active low
  anreg_exp_if.keeper fl      // Set, clear and flag levels
);

  logic par_fault;
  logic page;

  // A set in the clearing cycle wins, so no event is lost to a read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      par_fault <= 1'b0;
    end else if (fl.fault_set) begin
      par_fault <= 1'b1;
    end else if (fl.rd_clear) begin
      par_fault <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page <= 1'b0;
    end else if (fl.page_set) begin
      page <= 1'b1;
    end else if (fl.rd_clear) begin
      page <= 1'b0;
    end
  end

  assign fl.fault_flag = par_fault;
  assign fl.page_flag = page;

  sequence s_fault_held;
    par_fault && !fl.rd_clear;
  endsequence

  AST_PAR_FAULT_STAYS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_fault_held |=> par_fault)
    else $error("fault flag dropped without a read");

  AST_PAR_FAULT_SETS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fl.fault_set |=> par_fault)
    else $error("fault flag not latched");

  AST_PAGE_SET_WINS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fl.page_set && fl.rd_clear |=> page)
    else $error("page event lost to a read");

  AST_PAGE_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fl.rd_clear && !fl.page_set |=> !page)
    else $error("page flag not cleared by read");

endmodule
`default_nettype wire

/* File: rtl/anreg_autoneg_regs.sv */
// Auto-negotiation advertisement, partner, expansion and bypass registers
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - Advertisement register contents go out as our abilities during negotiation.
// - Advertisement bit 15, next page, always reads 0.
// - Negotiation engine drives outgoing acknowledge bit 14; software leaves it alone.
// - Advertisement bit 13 is writable remote fault, reset 0.
// - Reserved bits are written 0 by software and read as 0.
// - Advertisement bit 10 is writable flow-control capability, reset 0.
// - Advertisement bit 9, T4 ability, is always 0.
// - Advertisement bits 8 to 5 are writable abilities, reset to 1.
// - Advertisement bits 4-0 are a writable selector, reset 00001.
// - Partner register captures received abilities; ability bits read-only, reset 0.
// - Partner bit 14 follows the acknowledge in incoming bursts.
// - Partner bits 15,13,9..5 show partner next page, fault and abilities.
// - Partner bit 10 is read-write flow control flag, reset 0.
// - Partner bits 4-0 are read-only selector, reset 00000.
// - Expansion bit 4 latches a parallel detection fault until cleared.
// - Expansion bit 3 shows the partner has a next page.
// - Expansion bit 2, local next page ability, is always 0.
// - Expansion bit 1 latches a new page; reading register 6 clears it.
// - Expansion bit 0 shows the partner can auto-negotiate.
// - Configuration bit 15 bypasses block encoder and decoder, reset 0.
// - Configuration bit 14 bypasses scrambler and descrambler, reset 0.
// - Basic status remote fault is set after partner fault bit sets.
module anreg_autoneg_regs (
  input wire logic CLK_SYS_I,            // 20 MHz system clock
  input wire logic ARST_N_I,             // Asynchronous reset, active low
  input wire logic [4:0] MGMT_ADDR_I,    // Management register address
  input wire logic MGMT_WR_I,            // Write strobe, one cycle
  input wire logic MGMT_RD_I,            // Read strobe, one cycle
  input wire logic [15:0] MGMT_WDATA_I,  // Write data
  output logic [15:0] MGMT_RDATA_O,      // Read data, registered
  output logic MGMT_RVALID_O,            // Read data valid pulse
  input wire logic ANEG_ACK_I,           // Acknowledge from negotiation engine
  output logic [15:0] ADV_WORD_O,        // Word to send in outgoing bursts
  input wire logic PAGE_RX_I,            // New page received pulse
  input wire logic [15:0] PAGE_WORD_I,   // Received link code word
  input wire logic PARTNER_AN_ABLE_I,    // Partner negotiates, level
  input wire logic PAR_FAULT_EVENT_I,    // Parallel detection fault pulse
  output logic REMOTE_FAULT_SET_O,       // Sets basic status remote fault
  output logic BLOCK_CODE_BYPASS_O,      // Block code bypass level
  output logic SCRAMBLER_BYPASS_O        // Scrambler bypass level
);

  logic [anreg_pkg::RESET_SYNC_STAGES-1:0] rst_sync;
  logic rst_n;
  logic [15:0] autoneg_advertisement;
  logic [15:0] link_partner_ability;
  logic [15:0] vendor_phy_configuration;
  logic [15:0] next_rdata;
  logic partner_fault_seen;
  logic wr_adv;
  logic wr_lp;
  logic wr_cfg;
  logic rd_exp;

  anreg_exp_if exp_bus ();

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] target);
    hit = (addr == target);
  endfunction

  // Release of reset is synchronised; assertion stays asynchronous
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_sync <= '0;
    end else begin
      rst_sync <= {rst_sync[anreg_pkg::RESET_SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = rst_sync[anreg_pkg::RESET_SYNC_STAGES-1];

  assign wr_adv = MGMT_WR_I && hit(MGMT_ADDR_I, anreg_pkg::ADDR_ADV);
  assign wr_lp = MGMT_WR_I && hit(MGMT_ADDR_I, anreg_pkg::ADDR_LP);
  assign wr_cfg = MGMT_WR_I && hit(MGMT_ADDR_I, anreg_pkg::ADDR_CFG);
  assign rd_exp = MGMT_RD_I && hit(MGMT_ADDR_I, anreg_pkg::ADDR_EXP);

  // Masking keeps fixed-zero and reserved bits out of storage
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      autoneg_advertisement <= anreg_pkg::ADV_RESET;
    end else if (wr_adv) begin
      autoneg_advertisement <= MGMT_WDATA_I & anreg_pkg::ADV_WR_MASK;
    end
  end

  // Ack is taken live from the engine, never from software
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      ADV_WORD_O <= anreg_pkg::ADV_RESET;
    end else begin
      ADV_WORD_O <= autoneg_advertisement;
      ADV_WORD_O[anreg_pkg::POS_ACK] <= ANEG_ACK_I;
    end
  end

  // A received page overrides a software write to the flow bit
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      link_partner_ability <= anreg_pkg::LP_RESET;
    end else if (PAGE_RX_I) begin
      link_partner_ability <= PAGE_WORD_I & anreg_pkg::LP_CAPTURE_MASK;
    end else if (wr_lp) begin
      link_partner_ability[anreg_pkg::POS_FC] <= MGMT_WDATA_I[anreg_pkg::POS_FC];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      vendor_phy_configuration <= anreg_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      vendor_phy_configuration <= MGMT_WDATA_I & anreg_pkg::CFG_WR_MASK;
    end
  end
  assign BLOCK_CODE_BYPASS_O = vendor_phy_configuration[anreg_pkg::POS_BLK_BYP];
  assign SCRAMBLER_BYPASS_O = vendor_phy_configuration[anreg_pkg::POS_SCR_BYP];

  // One pulse per rise of the partner fault bit; basic status latches it
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      partner_fault_seen <= 1'b0;
      REMOTE_FAULT_SET_O <= 1'b0;
    end else begin
      partner_fault_seen <= link_partner_ability[anreg_pkg::POS_REMOTE_FAULT];
      REMOTE_FAULT_SET_O <= link_partner_ability[anreg_pkg::POS_REMOTE_FAULT] &&
                            !partner_fault_seen;
    end
  end

  assign exp_bus.fault_set = PAR_FAULT_EVENT_I;
  assign exp_bus.page_set = PAGE_RX_I;
  assign exp_bus.rd_clear = rd_exp;

  anreg_latch_flags u_flags (
    .clk_i(CLK_SYS_I),
    .rst_n_i(rst_n),
    .fl(exp_bus.keeper)
  );

  // Read returns the value before any clear-on-read of the same cycle
  always_comb begin
    next_rdata = anreg_pkg::READ_NONE;
    case (MGMT_ADDR_I)
      anreg_pkg::ADDR_ADV: begin
        next_rdata = autoneg_advertisement;
        next_rdata[anreg_pkg::POS_ACK] = ANEG_ACK_I;
      end
      anreg_pkg::ADDR_LP: begin
        next_rdata = link_partner_ability;
      end
      anreg_pkg::ADDR_EXP: begin
        next_rdata[anreg_pkg::POS_PAR_FAULT] = exp_bus.fault_flag;
        next_rdata[anreg_pkg::POS_LP_NEXT] =
          link_partner_ability[anreg_pkg::POS_NEXT_PAGE];
        next_rdata[anreg_pkg::POS_LOCAL_NEXT] = 1'b0;
        next_rdata[anreg_pkg::POS_PAGE] = exp_bus.page_flag;
        next_rdata[anreg_pkg::POS_LP_AN] = PARTNER_AN_ABLE_I;
      end
      anreg_pkg::ADDR_CFG: begin
        next_rdata = vendor_phy_configuration;
      end
      default: begin
        next_rdata = anreg_pkg::READ_NONE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      MGMT_RDATA_O <= anreg_pkg::READ_NONE;
      MGMT_RVALID_O <= 1'b0;
    end else begin
      MGMT_RVALID_O <= MGMT_RD_I;
      if (MGMT_RD_I) begin
        MGMT_RDATA_O <= next_rdata;
      end
    end
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!rst_n);

  sequence s_adv_write;
    wr_adv ##1 !wr_adv;
  endsequence

  AST_ADV_SENT: assert property (
    s_adv_write |=> (ADV_WORD_O & anreg_pkg::ADV_WR_MASK) ==
                    ($past(MGMT_WDATA_I, 2) & anreg_pkg::ADV_WR_MASK))
    else $error("advertised word does not follow the write");

  AST_ADV_FIXED_ZERO: assert property (
    !ADV_WORD_O[anreg_pkg::POS_NEXT_PAGE] && !ADV_WORD_O[anreg_pkg::POS_T4])
    else $error("next page or T4 advertised");

  AST_ACK_FROM_ENGINE: assert property (
    ANEG_ACK_I ##1 wr_adv |=> ADV_WORD_O[anreg_pkg::POS_ACK] == $past(ANEG_ACK_I))
    else $error("outgoing ack not from engine");

  sequence s_page_in;
    PAGE_RX_I;
  endsequence

  AST_PAGE_CAPTURE: assert property (
    s_page_in |=> link_partner_ability ==
                  ($past(PAGE_WORD_I) & anreg_pkg::LP_CAPTURE_MASK) && exp_bus.page_flag)
    else $error("partner word and page flag not updated together");

  AST_LP_SEL_RO: assert property (
    wr_lp && !PAGE_RX_I |=> $stable(link_partner_ability[anreg_pkg::POS_SEL_MSB:0]))
    else $error("partner selector changed by software");

  AST_LP_FC_WRITE: assert property (
    wr_lp && !PAGE_RX_I |=> link_partner_ability[anreg_pkg::POS_FC] ==
                            $past(MGMT_WDATA_I[anreg_pkg::POS_FC]))
    else $error("partner flow bit not written");

  AST_EXP_READ: assert property (
    rd_exp ##1 1'b1 |-> MGMT_RVALID_O && MGMT_RDATA_O[15:5] == 11'h000 &&
                        !MGMT_RDATA_O[anreg_pkg::POS_LOCAL_NEXT] &&
                        MGMT_RDATA_O[anreg_pkg::POS_LP_NEXT] ==
                        $past(link_partner_ability[anreg_pkg::POS_NEXT_PAGE]))
    else $error("expansion read value wrong");

  AST_RF_STATUS: assert property (
    $rose(link_partner_ability[anreg_pkg::POS_REMOTE_FAULT]) |=> REMOTE_FAULT_SET_O)
    else $error("remote fault not passed to status");

  AST_BYPASS_WRITE: assert property (
    wr_cfg |=> BLOCK_CODE_BYPASS_O == $past(MGMT_WDATA_I[anreg_pkg::POS_BLK_BYP]) &&
               SCRAMBLER_BYPASS_O == $past(MGMT_WDATA_I[anreg_pkg::POS_SCR_BYP]))
    else $error("bypass bits do not follow the write");

  sequence s_adv_read;
    MGMT_RD_I && MGMT_ADDR_I == anreg_pkg::ADDR_ADV;
  endsequence

  sequence s_unmapped_read;
    MGMT_RD_I && MGMT_ADDR_I != anreg_pkg::ADDR_ADV && MGMT_ADDR_I != anreg_pkg::ADDR_LP &&
    MGMT_ADDR_I != anreg_pkg::ADDR_EXP && MGMT_ADDR_I != anreg_pkg::ADDR_CFG;
  endsequence

  AST_ADV_READ_ZEROS: assert property (
    s_adv_read |=> !MGMT_RDATA_O[anreg_pkg::POS_NEXT_PAGE] &&
                   !MGMT_RDATA_O[anreg_pkg::POS_T4] && MGMT_RDATA_O[12:11] == 2'b00)
    else $error("advertisement read shows a fixed bit set");

  AST_ADV_READ_ACK: assert property (
    s_adv_read |=> MGMT_RDATA_O[anreg_pkg::POS_ACK] == $past(ANEG_ACK_I))
    else $error("advertisement read ack not from engine");

  AST_ADV_STORE_MASK: assert property (
    (autoneg_advertisement & ~anreg_pkg::ADV_WR_MASK) == 16'h0000)
    else $error("advertisement holds a fixed bit");

  AST_ADV_WRITE: assert property (
    wr_adv |=> autoneg_advertisement == ($past(MGMT_WDATA_I) & anreg_pkg::ADV_WR_MASK))
    else $error("advertisement write not stored");

  AST_ADV_HOLD: assert property (
    !wr_adv |=> $stable(autoneg_advertisement))
    else $error("advertisement changed without a write");

  AST_ADV_WORD_FOLLOWS: assert property (
    1'b1 |=> (ADV_WORD_O & 16'hBFFF) == ($past(autoneg_advertisement) & 16'hBFFF))
    else $error("outgoing word does not follow the register");

  AST_ACK_LIVE: assert property (
    1'b1 |=> ADV_WORD_O[anreg_pkg::POS_ACK] == $past(ANEG_ACK_I))
    else $error("outgoing ack does not follow the engine");

  AST_LP_HOLD: assert property (
    !PAGE_RX_I && !wr_lp |=> $stable(link_partner_ability))
    else $error("partner word changed without a page or write");

  AST_LP_ACK_FROM_PAGE: assert property (
    s_page_in |=> link_partner_ability[anreg_pkg::POS_ACK] ==
                  $past(PAGE_WORD_I[anreg_pkg::POS_ACK]))
    else $error("partner ack not taken from the page");

  AST_LP_RESERVED: assert property (
    link_partner_ability[12:11] == 2'b00)
    else $error("partner reserved bits set");

  AST_LP_RO_ON_WRITE: assert property (
    wr_lp && !PAGE_RX_I |=> (link_partner_ability & 16'hFBFF) ==
                            ($past(link_partner_ability) & 16'hFBFF))
    else $error("partner ability bits changed by software");

  AST_CFG_MASK: assert property (
    (vendor_phy_configuration & ~anreg_pkg::CFG_WR_MASK) == 16'h0000)
    else $error("configuration holds bits outside the bypasses");

  AST_CFG_HOLD: assert property (
    !wr_cfg |=> $stable(vendor_phy_configuration))
    else $error("configuration changed without a write");

  AST_RF_PULSE_ONE: assert property (
    REMOTE_FAULT_SET_O |=> !REMOTE_FAULT_SET_O)
    else $error("remote fault set longer than one cycle");

  AST_RF_ONLY_ON_RISE: assert property (
    REMOTE_FAULT_SET_O |-> $past(link_partner_ability[anreg_pkg::POS_REMOTE_FAULT]) &&
                           !$past(link_partner_ability[anreg_pkg::POS_REMOTE_FAULT], 2))
    else $error("remote fault set without a rise");

  AST_EXP_PAGE_READ: assert property (
    rd_exp |=> MGMT_RDATA_O[anreg_pkg::POS_PAGE] == $past(exp_bus.page_flag))
    else $error("page flag read wrong");

  AST_EXP_FAULT_READ: assert property (
    rd_exp |=> MGMT_RDATA_O[anreg_pkg::POS_PAR_FAULT] == $past(exp_bus.fault_flag))
    else $error("detection fault read wrong");

  AST_EXP_AN_READ: assert property (
    rd_exp |=> MGMT_RDATA_O[anreg_pkg::POS_LP_AN] == $past(PARTNER_AN_ABLE_I))
    else $error("partner negotiation ability read wrong");

  AST_UNMAPPED_READ: assert property (
    s_unmapped_read |=> MGMT_RVALID_O && MGMT_RDATA_O == anreg_pkg::READ_NONE)
    else $error("unmapped read not zero");

endmodule
`default_nettype wire

/* File: sim/anreg_engine_model.sv */
// Behavioural stand-in for the negotiation engine and the remote partner
`timescale 1ns/10ps
`default_nettype none
module anreg_engine_model (
  input wire logic clk_i,          // System clock
  output logic ack_o,              // Acknowledge level for outgoing bursts
  output logic page_rx_o,          // New page pulse
  output logic [15:0] page_word_o, // Received link code word
  output logic an_able_o,          // Partner negotiates
  output logic fault_o             // Parallel detection fault pulse
);
  initial begin
    ack_o = 1'b0;
    page_rx_o = 1'b0;
    page_word_o = 16'h0000;
    an_able_o = 1'b0;
    fault_o = 1'b0;
  end
  task automatic set_levels(input logic ack, input logic able);
    @(posedge clk_i);
    #1;
    ack_o = ack;
    an_able_o = able;
  endtask
  task automatic send_page(input logic [15:0] w);
    @(posedge clk_i);
    #1;
    page_rx_o = 1'b1;
    page_word_o = w;
    @(posedge clk_i);
    #1;
    page_rx_o = 1'b0;
    // Word is stale once the pulse ends, so never leave it looking valid
    page_word_o = ~w;
  endtask
  task automatic fault_pulse();
    @(posedge clk_i);
    #1;
    fault_o = 1'b1;
    @(posedge clk_i);
    #1;
    fault_o = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: sim/phy_autoneg_register_set_bench.sv */
// Self-checking bench for the auto-negotiation register set
`timescale 1ns/10ps
`default_nettype none
module phy_autoneg_register_set_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, adv_word, page_word;
  logic rvalid, rf_set, blk_byp, scr_byp, ack, page_rx, an_able, par_fault;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  anreg_autoneg_regs uut (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .MGMT_ADDR_I(addr),
    .MGMT_WR_I(wr), .MGMT_RD_I(rd), .MGMT_WDATA_I(wdata), .MGMT_RDATA_O(rdata),
    .MGMT_RVALID_O(rvalid), .ANEG_ACK_I(ack), .ADV_WORD_O(adv_word), .PAGE_RX_I(page_rx),
    .PAGE_WORD_I(page_word), .PARTNER_AN_ABLE_I(an_able), .PAR_FAULT_EVENT_I(par_fault),
    .REMOTE_FAULT_SET_O(rf_set), .BLOCK_CODE_BYPASS_O(blk_byp),
    .SCRAMBLER_BYPASS_O(scr_byp));
  anreg_engine_model pm (.clk_i(clk), .ack_o(ack), .page_rx_o(page_rx),
    .page_word_o(page_word), .an_able_o(an_able), .fault_o(par_fault));
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    check("read valid", 16'h0001, {15'h0000, rvalid});
    check($sformatf("register %h", a), exp, rdata);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Whole run needs under 100 cycles; the ceiling of 3000 leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("Run exceeded its cycle limit");
      test_done();
    end
  end
  initial begin
    step(12);
    arst_n = 1'b1;
    step(3);
    check("adv word", 16'h01E1, adv_word);
    rd_reg(5'h04, 16'h01E1);
    rd_reg(5'h05, 16'h0000);
    rd_reg(5'h06, 16'h0000);
    rd_reg(5'h10, 16'h0000);
    $display("Test reset values done");
    wr_reg(5'h04, 16'hFFFF);
    step(1);
    check("adv word", 16'h25FF, adv_word);
    rd_reg(5'h04, 16'h25FF);
    pm.set_levels(1'b1, 1'b1);
    step(1);
    check("adv word ack", 16'h65FF, adv_word);
    wr_reg(5'h04, 16'h0000);
    rd_reg(5'h04, 16'h4000);
    pm.set_levels(1'b0, 1'b1);
    $display("Test advertisement done");
    wr_reg(5'h10, 16'hFFFF);
    rd_reg(5'h10, 16'hC000);
    check("bypasses", 16'h0003, {14'h0000, blk_byp, scr_byp});
    wr_reg(5'h10, 16'h4000);
    step(1);
    check("bypasses", 16'h0001, {14'h0000, blk_byp, scr_byp});
    $display("Test configuration done");
    pm.send_page(16'hFFFF);
    step(1);
    check("fault set", 16'h0001, {15'h0000, rf_set});
    step(1);
    check("fault set", 16'h0000, {15'h0000, rf_set});
    rd_reg(5'h05, 16'hE7FF);
    rd_reg(5'h06, 16'h000B);
    rd_reg(5'h06, 16'h0009);
    wr_reg(5'h05, 16'h0000);
    rd_reg(5'h05, 16'hE3FF);
    wr_reg(5'h05, 16'h0400);
    rd_reg(5'h05, 16'hE7FF);
    $display("Test partner page done");
    pm.fault_pulse();
    rd_reg(5'h06, 16'h0019);
    rd_reg(5'h06, 16'h0009);
    pm.send_page(16'h0021);
    rd_reg(5'h06, 16'h0003);
    rd_reg(5'h05, 16'h0021);
    wr_reg(5'h07, 16'hFFFF);
    rd_reg(5'h07, 16'h0000);
    $display("Test expansion done");
    test_done();
  end
endmodule
`default_nettype wire
